// [hdl/aolcl_consts.svh]
`ifndef AOLCL_CONSTS_SVH
`define AOLCL_CONSTS_SVH

// register addresses
`define AOLCL_CH_FIRST 5'h00
`define AOLCL_CH_LAST 5'h03
`define AOLCL_CFG_FIRST 5'h08
`define AOLCL_CRC_FIRST 5'h09
`define AOLCL_STATUS_ADDR 5'h0A
`define AOLCL_KEY_ADDR 5'h1F

// reset values, key and CRC polynomial
`define AOLCL_KEY_OPEN 8'hA5
`define AOLCL_STATUS_RST 24'h000008
`define AOLCL_POLY 16'h8005

// status_comm_register fields
`define AOLCL_B_CRC_EN 0
`define AOLCL_B_CRC_W32 1
`define AOLCL_B_INT_EN 2
`define AOLCL_B_LINK 3
`define AOLCL_F_READY_LO 8
`define AOLCL_READY_MASK 24'h000F00

// counts
`define AOLCL_CRC_PERIOD_LAST 5'h0F
`define AOLCL_CRC_SLOT_LAST 5'h0B
`define AOLCL_CTRL_LAST 5'h07
`define AOLCL_WORD_LAST 5'h17
`define AOLCL_CSUM16_LAST 5'h0F
`define AOLCL_CSUM32_LAST 5'h1F

`endif

// [hdl/aolcl_pkg.sv]
package aolcl_pkg;

    typedef logic [23:0] aolcl_word_t;

    typedef logic [31:0][23:0] aolcl_map_t;

    typedef enum logic [1:0] {
        ST_CTRL,
        ST_WORD,
        ST_CSUM
    } aolcl_link_e;

    typedef struct packed {
        logic [4:0] addr;
        aolcl_word_t data;
    } aolcl_wr_s;

endpackage

// [hdl/aolcl_top.sv]
// What this block does
// - channel results 0x00-0x03 behind two latches
// - first latch on data ready, linked capture
// - second latch freezes word at read start
// - ready flags read 0 when data new
// - checksum after each read sequence when enabled
// - checksum is CRC-16 polynomial 0x8005
// - width bit selects 16 or 32-bit field
// - sequence plus checksum gives zero remainder
// - checksum only after last address of set
// - key 0xA5 at 0x1F unlocks writes
// - locked map ignores writes except 0x1F
// - config checksum only while locked, else zero
// - config checksum every 16 modulator periods
// - config checksum cleared by reset
// - message 0x09-0x1F, ready ones, field zero
// - first locked checksum becomes reference
// - mismatch with interrupt holds ready pin low
// - power-up: flag off, map unlocked
// - ready pin pulses half a modulator period
`timescale 1ns/1ns
`default_nettype none
`include "aolcl_consts.svh"

module aolcl_top
    import aolcl_pkg::*;
(
    // modulator clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // converter results
    input wire logic [3:0] conv_valid,
    input wire logic [3:0] ch_active,
    input wire aolcl_word_t [3:0] conv_data,
    // serial link
    input wire logic sck,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    // data-ready pin
    output logic data_ready_n
);

    function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
        crc_bit = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `AOLCL_POLY : 16'h0000);
    endfunction

    function automatic logic [15:0] crc_word(input logic [15:0] c, input aolcl_word_t w);
        logic [15:0] r;
        r = c;
        for (int i = 23; i >= 0; i--) begin
            r = crc_bit(r, w[i]);
        end
        crc_word = r;
    endfunction

    // ---------------- modulator clock domain ----------------
    logic [23:0] stage1 [4];
    logic [3:0] ready;
    logic [3:0] cap;
    logic [23:0] cfg_ff [8:30];
    logic [7:0] key_ff;
    logic unlocked;
    logic link_en;
    logic int_en;
    aolcl_word_t status_word;

    // sck-side toggles: {ack, write, channel reads}
    logic [5:0] x_in;
    logic [5:0] x_s1_ff;
    logic [5:0] x_s2_ff;
    logic [5:0] x_s3_ff;
    logic [5:0] x_last_ff;
    logic [5:0] x_chg;

    aolcl_wr_s wr_ff;
    logic wr_tog_ff;
    logic [3:0] rd_tog_ff;
    logic ack_ff;

    assign status_word = cfg_ff[`AOLCL_STATUS_ADDR];
    assign link_en = status_word[`AOLCL_B_LINK];
    assign int_en = status_word[`AOLCL_B_INT_EN];
    assign unlocked = key_ff == `AOLCL_KEY_OPEN;

    assign x_in = {ack_ff, wr_tog_ff, rd_tog_ff};
    // a change counts only once the second and third stages agree
    assign x_chg = ~(x_s2_ff ^ x_s3_ff) & (x_s3_ff ^ x_last_ff);

    always_ff @(posedge clk_sys) begin
        x_s1_ff <= x_in;
        x_s2_ff <= x_s1_ff;
        x_s3_ff <= x_s2_ff;
        if (sys_rst) begin
            x_last_ff <= x_s3_ff;
        end else begin
            x_last_ff <= x_last_ff ^ x_chg;
        end
    end

    for (genvar g = 0; g < 4; g++) begin : g_ch
        logic [23:0] hold_ff;
        logic new_ff;
        assign cap[g] = link_en ? ((|conv_valid) & ch_active[g]) : conv_valid[g];
        always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
                hold_ff <= 24'h000000;
                new_ff <= 1'b0;
            end else begin
                if (cap[g]) begin
                    hold_ff <= conv_data[g];
                end
                // a capture in the same cycle as a read start keeps the flag set
                if (cap[g]) begin
                    new_ff <= 1'b1;
                end else if (x_chg[g]) begin
                    new_ff <= 1'b0;
                end
            end
        end
        assign stage1[g] = hold_ff;
        assign ready[g] = new_ff;
    end

    // register writes arrive from the link as a held word plus toggle
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            key_ff <= `AOLCL_KEY_OPEN;
            for (int a = 8; a <= 30; a++) begin
                cfg_ff[a] <= (a == `AOLCL_STATUS_ADDR) ? `AOLCL_STATUS_RST : 24'h000000;
            end
        end else if (x_chg[4]) begin
            if (wr_ff.addr == `AOLCL_KEY_ADDR) begin
                key_ff <= wr_ff.data[23:16];
            end else if (unlocked && wr_ff.addr >= `AOLCL_CFG_FIRST) begin
                cfg_ff[wr_ff.addr] <= wr_ff.data;
            end
        end
    end

    // configuration checksum engine
    logic [4:0] cc_cnt_ff;
    logic [15:0] cc_acc_ff;
    logic [15:0] cfg_crc_ff;
    logic [15:0] ref_ff;
    logic ref_ok_ff;
    logic flag_ff;
    logic [15:0] nxt_acc;
    logic [4:0] msg_idx;

    function automatic aolcl_word_t msg_word(input logic [4:0] a);
        if (a == `AOLCL_KEY_ADDR) begin
            msg_word = {key_ff, 16'h0000};
        end else if (a == `AOLCL_STATUS_ADDR) begin
            msg_word = cfg_ff[a] | `AOLCL_READY_MASK;
        end else if (a >= `AOLCL_CRC_FIRST) begin
            msg_word = cfg_ff[a];
        end else begin
            msg_word = 24'h000000;
        end
    endfunction

    // two words a cycle: 23 words finish in 12 of the 16 cycles
    always_comb begin
        msg_idx = `AOLCL_CRC_FIRST + {cc_cnt_ff[3:0], 1'b0};
        nxt_acc = crc_word(cc_acc_ff, msg_word(msg_idx));
        if (cc_cnt_ff != `AOLCL_CRC_SLOT_LAST) begin
            nxt_acc = crc_word(nxt_acc, msg_word(msg_idx + 5'h01));
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst || unlocked) begin
            cc_cnt_ff <= 5'h00;
            cc_acc_ff <= 16'h0000;
            cfg_crc_ff <= 16'h0000;
            ref_ff <= 16'h0000;
            ref_ok_ff <= 1'b0;
            flag_ff <= 1'b0;
        end else begin
            cc_cnt_ff <= (cc_cnt_ff == `AOLCL_CRC_PERIOD_LAST) ? 5'h00 : cc_cnt_ff + 5'h01;
            if (cc_cnt_ff <= `AOLCL_CRC_SLOT_LAST) begin
                cc_acc_ff <= nxt_acc;
            end
            if (cc_cnt_ff == `AOLCL_CRC_PERIOD_LAST) begin
                cc_acc_ff <= 16'h0000;
                cfg_crc_ff <= cc_acc_ff;
                if (!ref_ok_ff) begin
                    ref_ff <= cc_acc_ff;
                    ref_ok_ff <= 1'b1;
                end else if (int_en && cc_acc_ff != ref_ff) begin
                    flag_ff <= 1'b1;
                end
            end
        end
    end

    // data-ready pulse: the two toggles differ for half a clock period
    logic pos_tog_ff;
    logic neg_tog_ff;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pos_tog_ff <= 1'b0;
        end else if (|cap) begin
            pos_tog_ff <= ~pos_tog_ff;
        end
    end

    always_ff @(negedge clk_sys) begin
        if (sys_rst) begin
            neg_tog_ff <= 1'b0;
        end else begin
            neg_tog_ff <= pos_tog_ff;
        end
    end

    assign data_ready_n = ~((pos_tog_ff ^ neg_tog_ff) | flag_ff);

    // cs_n through three stages; the link counts as idle only while the second and third agree high
    logic [2:0] cs_sync_ff;
    logic link_idle;

    always_ff @(posedge clk_sys) begin
        cs_sync_ff <= {cs_sync_ff[1:0], cs_n};
    end

    assign link_idle = cs_sync_ff[1] & cs_sync_ff[2];

    // snapshot published to the link by toggle handshake
    aolcl_map_t live;
    aolcl_map_t pub_ff;
    logic pub_req_ff;

    always_comb begin
        live = '0;
        for (int a = 0; a < 32; a++) begin
            if (a <= 3) begin
                live[a] = stage1[a];
            end else if (a == `AOLCL_KEY_ADDR) begin
                live[a] = {key_ff, cfg_crc_ff};
            end else if (a >= 8) begin
                live[a] = cfg_ff[a];
            end
        end
        live[`AOLCL_STATUS_ADDR][`AOLCL_F_READY_LO +: 4] = ~ready;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pub_req_ff <= 1'b0;
            pub_ff <= '0;
        end else if (pub_req_ff == x_last_ff[5]) begin
            pub_ff <= live;
            pub_req_ff <= ~pub_req_ff;
        end else if (link_idle) begin
            // a pending word would otherwise go stale between frames; no sck edge
            // samples it while cs_n is high, so the first sck edge must come more
            // than two clk_sys periods after cs_n falls
            pub_ff <= live;
        end
    end

    // ---------------- serial clock domain ----------------
    // sck stands still outside frames, so the asynchronous resets here
    // release while no edge can arrive
    logic r_s1_ff;
    logic r_s2_ff;
    logic r_s3_ff;
    aolcl_map_t shadow_ff;

    always_ff @(posedge sck or posedge sys_rst) begin
        if (sys_rst) begin
            r_s1_ff <= 1'b0;
            r_s2_ff <= 1'b0;
            r_s3_ff <= 1'b0;
            ack_ff <= 1'b0;
            shadow_ff <= '0;
        end else begin
            r_s1_ff <= pub_req_ff;
            r_s2_ff <= r_s1_ff;
            r_s3_ff <= r_s2_ff;
            if (r_s2_ff == r_s3_ff && r_s3_ff != ack_ff) begin
                shadow_ff <= pub_ff;
                ack_ff <= r_s3_ff;
            end
        end
    end

    aolcl_link_e state_ff;
    aolcl_link_e nxt_state;
    logic [4:0] cnt_ff;
    logic [4:0] nxt_cnt;
    logic [4:0] addr_ff;
    logic [4:0] nxt_addr;
    logic [4:0] first_ff;
    logic [4:0] nxt_first;
    logic [4:0] last_ff;
    logic [4:0] nxt_last;
    logic rd_ff;
    logic nxt_rd;
    logic [23:0] in_ff;
    logic [23:0] nxt_in;
    logic [31:0] out_ff;
    logic [31:0] nxt_out;
    logic [15:0] crc_ff;
    logic [15:0] nxt_crc;
    logic load;
    logic seq_start;
    logic wr_fire;
    logic [4:0] load_addr;
    logic [7:0] ctrl;
    logic crc_en;
    logic crc_w32;

    assign crc_en = shadow_ff[`AOLCL_STATUS_ADDR][`AOLCL_B_CRC_EN];
    assign crc_w32 = shadow_ff[`AOLCL_STATUS_ADDR][`AOLCL_B_CRC_W32];

    always_comb begin
        ctrl = {in_ff[6:0], sdi};
        nxt_state = state_ff;
        nxt_cnt = cnt_ff + 5'h01;
        nxt_addr = addr_ff;
        nxt_first = first_ff;
        nxt_last = last_ff;
        nxt_rd = rd_ff;
        nxt_in = {in_ff[22:0], sdi};
        nxt_out = {out_ff[30:0], 1'b0};
        nxt_crc = crc_ff;
        load = 1'b0;
        seq_start = 1'b0;
        wr_fire = 1'b0;
        load_addr = addr_ff;
        case (state_ff)
            ST_CTRL: begin
                if (cnt_ff == `AOLCL_CTRL_LAST) begin
                    nxt_addr = ctrl[5:1];
                    nxt_rd = ctrl[0];
                    nxt_first = (ctrl[5:1] <= `AOLCL_CH_LAST) ? `AOLCL_CH_FIRST : ctrl[5:1];
                    nxt_last = (ctrl[5:1] <= `AOLCL_CH_LAST) ? `AOLCL_CH_LAST : ctrl[5:1];
                    nxt_state = ST_WORD;
                    nxt_cnt = 5'h00;
                    load = ctrl[0];
                    seq_start = 1'b1;
                    load_addr = ctrl[5:1];
                end
            end
            ST_WORD: begin
                if (rd_ff) begin
                    nxt_crc = crc_bit(crc_ff, out_ff[31]);
                end
                if (cnt_ff == `AOLCL_WORD_LAST) begin
                    nxt_cnt = 5'h00;
                    if (!rd_ff) begin
                        wr_fire = 1'b1;
                        if (addr_ff == `AOLCL_KEY_ADDR) begin
                            nxt_addr = `AOLCL_CFG_FIRST;
                        end else if (addr_ff >= `AOLCL_CFG_FIRST) begin
                            nxt_addr = addr_ff + 5'h01;
                        end
                    end else if (addr_ff != last_ff) begin
                        nxt_addr = addr_ff + 5'h01;
                        load = 1'b1;
                        load_addr = addr_ff + 5'h01;
                    end else if (crc_en) begin
                        nxt_state = ST_CSUM;
                        nxt_out = {nxt_crc, 16'h0000};
                    end else begin
                        nxt_addr = first_ff;
                        load = 1'b1;
                        seq_start = 1'b1;
                        load_addr = first_ff;
                    end
                end
            end
            ST_CSUM: begin
                if (cnt_ff == (crc_w32 ? `AOLCL_CSUM32_LAST : `AOLCL_CSUM16_LAST)) begin
                    nxt_state = ST_WORD;
                    nxt_cnt = 5'h00;
                    nxt_addr = first_ff;
                    load = 1'b1;
                    seq_start = 1'b1;
                    load_addr = first_ff;
                end
            end
            default: begin
                nxt_state = ST_CTRL;
            end
        endcase
        if (load) begin
            // later captures only reach the shadow, never this word
            nxt_out = {shadow_ff[load_addr], 8'h00};
        end
        if (seq_start) begin
            nxt_crc = 16'h0000;
        end
    end

    always_ff @(posedge sck or posedge cs_n or posedge sys_rst) begin
        if (cs_n || sys_rst) begin
            state_ff <= ST_CTRL;
            cnt_ff <= 5'h00;
            addr_ff <= 5'h00;
            first_ff <= 5'h00;
            last_ff <= 5'h00;
            rd_ff <= 1'b0;
            in_ff <= 24'h000000;
            out_ff <= 32'h00000000;
            crc_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            addr_ff <= nxt_addr;
            first_ff <= nxt_first;
            last_ff <= nxt_last;
            rd_ff <= nxt_rd;
            in_ff <= nxt_in;
            out_ff <= nxt_out;
            crc_ff <= nxt_crc;
        end
    end

    // write word and read marks outlive the frame
    always_ff @(posedge sck or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ff <= '0;
            wr_tog_ff <= 1'b0;
            rd_tog_ff <= 4'h0;
        end else begin
            if (wr_fire) begin
                wr_ff <= '{addr: addr_ff, data: nxt_in};
                wr_tog_ff <= ~wr_tog_ff;
            end
            if (load && load_addr <= `AOLCL_CH_LAST) begin
                rd_tog_ff[load_addr[1:0]] <= ~rd_tog_ff[load_addr[1:0]];
            end
        end
    end

    logic sdo_ff;
    logic oe_ff;

    always_ff @(negedge sck or posedge cs_n or posedge sys_rst) begin
        if (cs_n || sys_rst) begin
            sdo_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else begin
            sdo_ff <= out_ff[31];
            oe_ff <= rd_ff && state_ff != ST_CTRL;
        end
    end

    assign sdo = sdo_ff;
    assign sdo_oe = oe_ff;

endmodule

`default_nettype wire

// [test/adc_output_latch_crc_lock_test.sv]
`timescale 1ns/1ns
`default_nettype none
module adc_output_latch_crc_lock_test;
    import aolcl_pkg::*;
    // host wait after a capture, in clk_sys cycles; value arbitrary
    localparam int DODR = 8;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] conv_valid = 4'h0;
    logic [3:0] ch_active = 4'b1011;
    aolcl_word_t [3:0] conv_data = '0;
    wire sck;
    wire cs_n;
    wire sdi;
    logic sdo;
    logic sdo_oe;
    logic data_ready_n;
    logic link = 1'b1;
    logic [15:0] c;
    logic [127:0] got;
    logic [127:0] exp_q[$];
    logic [127:0] msk_q[$];
    aolcl_word_t ch[4] = '{default: '0};
    aolcl_word_t cfg[32];
    int err_count = 0;
    int tests_run = 0;
    int seed = 7966;
    int cycles = 0;

    aolcl_top u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .conv_valid(conv_valid), .ch_active(ch_active),
        .conv_data(conv_data), .sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
        .data_ready_n(data_ready_n));
    aolcl_host_model u_host (.sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));

    always #25 clk_sys = ~clk_sys;

    task automatic tally_and_finish();
        $display("mismatches %0d, comparisons %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    function automatic logic [15:0] crc_step(input logic [15:0] r, input logic b);
        return {r[14:0], 1'b0} ^ ((r[15] ^ b) ? 16'h8005 : 16'h0000);
    endfunction

    // ready flags count as ones and the checksum field as zero
    function automatic logic [15:0] cfg_crc(input logic [7:0] key);
        logic [15:0] r;
        aolcl_word_t w;
        r = 16'h0000;
        for (int a = 9; a < 32; a++) begin
            w = (a == 10) ? (cfg[a] | 24'h000F00) : (a == 31) ? {key, 16'h0000} : cfg[a];
            for (int i = 23; i >= 0; i--) r = crc_step(r, w[i]);
        end
        return r;
    endfunction

    task automatic chk_word(input logic [127:0] g, input logic [127:0] e, input logic [127:0] m);
        tests_run++;
        if ((g & m) !== (e & m)) begin
            err_count++;
            $display("wrong value at %0t: serial read %h, expected %h", $time, g & m, e & m);
        end
    endtask

    // sampled after the falling edge, where a normal pulse is already over
    task automatic chk_pin(input logic e);
        @(negedge clk_sys);
        #2;
        tests_run++;
        if (data_ready_n !== e) begin
            err_count++;
            $display("wrong value at %0t: ready pin %b, expected %b", $time, data_ready_n, e);
        end
    endtask

    task automatic rd(input logic [4:0] a, input int n, input logic [127:0] e, input logic [127:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m & ((128'h1 << n) - 128'h1));
        u_host.xfer({2'b00, a, 1'b1}, n);
    endtask

    task automatic wr1(input logic [4:0] a, input aolcl_word_t w);
        u_host.wq.push_back(w);
        u_host.xfer({2'b00, a, 1'b0}, 24);
    endtask

    task automatic capture(input logic [3:0] v);
        @(posedge clk_sys);
        #2;
        for (int i = 0; i < 4; i++) conv_data[i] = 24'($random(seed));
        conv_valid = v;
        for (int i = 0; i < 4; i++) begin
            if (link ? (ch_active[i] && (|v)) : v[i]) ch[i] = conv_data[i];
        end
        @(posedge clk_sys);
        #2;
        conv_valid = 4'h0;
        repeat (DODR) @(posedge clk_sys);
    endtask

    task automatic do_reset();
        @(posedge clk_sys);
        #2;
        sys_rst = 1'b1;
        repeat (8) @(posedge clk_sys);
        #2;
        sys_rst = 1'b0;
        ch = '{default: '0};
        link = 1'b1;
        repeat (10) @(posedge clk_sys);
    endtask

    initial begin
        forever begin
            @(u_host.done_ev);
            got = '0;
            foreach (u_host.rx[i]) got = {got[126:0], u_host.rx[i]};
            chk_word(got, exp_q.pop_front(), msk_q.pop_front());
        end
    end

    initial begin
        do_reset();
        rd(5'h1F, 24, 24'hA50000, '1);
        rd(5'h0A, 24, 24'h000F08, '1);
        capture(4'b0100);
        rd(5'h00, 96, {ch[0], ch[1], ch[2], ch[3]}, '1);
        rd(5'h0A, 24, 24'h000F08, '1);
        link = 1'b0;
        wr1(5'h0A, 24'h000000);
        capture(4'b0010);
        rd(5'h0A, 24, 24'h000D00, '1);
        rd(5'h00, 96, {ch[0], ch[1], ch[2], ch[3]}, '1);
        fork
            rd(5'h00, 24, ch[0], '1);
            begin
                #3000;
                capture(4'b1111);
            end
        join
        rd(5'h00, 96, {ch[0], ch[1], ch[2], ch[3]}, '1);
        link = 1'b1;
        ch_active = 4'($random(seed));
        for (int w = 0; w < 2; w++) begin
            wr1(5'h0A, (w == 1) ? 24'h00000B : 24'h000009);
            capture(4'b1000);
            c = 16'h0000;
            for (int i = 23; i >= 0; i--) c = crc_step(c, ch[3][i]);
            if (w == 1) rd(5'h03, 80, {ch[3], c, 16'h0000, ch[0]}, '1);
            else rd(5'h03, 64, {ch[3], c, ch[0]}, '1);
        end
        for (int a = 9; a < 32; a++) cfg[a] = 24'($random(seed));
        cfg[10] = 24'h00000C;
        cfg[31] = 24'h000000;
        for (int a = 9; a < 32; a++) u_host.wq.push_back(cfg[a]);
        u_host.xfer(8'h12, 552);
        repeat (40) @(posedge clk_sys);
        rd(5'h1F, 24, {8'h00, cfg_crc(8'h00)}, '1);
        wr1(5'h0A, 24'h000009);
        rd(5'h0A, 24, 24'h00000C, 24'hFFF0FF);
        wr1(5'h1F, 24'h110000);
        repeat (40) @(posedge clk_sys);
        chk_pin(1'b0);
        capture(4'b1111);
        chk_pin(1'b0);
        rd(5'h1F, 24, {8'h11, cfg_crc(8'h11)}, '1);
        wr1(5'h1F, 24'hA50000);
        chk_pin(1'b1);
        rd(5'h1F, 24, 24'hA50000, '1);
        wr1(5'h0A, 24'h000008);
        wr1(5'h1F, 24'h000000);
        repeat (40) @(posedge clk_sys);
        wr1(5'h1F, 24'h220000);
        repeat (40) @(posedge clk_sys);
        chk_pin(1'b1);
        do_reset();
        rd(5'h1F, 24, 24'hA50000, '1);
        tally_and_finish();
    end
endmodule

bind aolcl_top aolcl_assertions u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .conv_valid(conv_valid),
    .ch_active(ch_active), .conv_data(conv_data), .sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe), .data_ready_n(data_ready_n));
`default_nettype wire

// [test/aolcl_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
module aolcl_assertions
    import aolcl_pkg::*;
(
    // modulator clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // converter results
    input wire logic [3:0] conv_valid,
    input wire logic [3:0] ch_active,
    input wire aolcl_word_t [3:0] conv_data,
    // serial link
    input wire logic sck,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe,
    // data-ready pin
    input wire logic data_ready_n
);
    logic [3:0] edge_cnt_ff;
    logic [7:0] ctrl_ff;

    // rising sck edges of the frame, saturating once the control byte is in
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            edge_cnt_ff <= 4'h0;
        end else if (edge_cnt_ff != 4'h8) begin
            edge_cnt_ff <= edge_cnt_ff + 4'h1;
        end
    end

    always_ff @(posedge sck) begin
        if (edge_cnt_ff != 4'h8) begin
            ctrl_ff <= {ctrl_ff[6:0], sdi};
        end
    end

    property p_rst_idle;
        @(posedge clk_sys) disable iff (sys_rst) $fell(sys_rst) |-> (data_ready_n && !sdo_oe) [*8];
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("pin active right after reset");

    // a low seen at a rising edge can only be the held flag, never a pulse
    property p_flag_hold;
        @(posedge clk_sys) disable iff (sys_rst) !data_ready_n && cs_n |=> !data_ready_n;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("ready pin released while flagged");

    property p_pulse;
        @(negedge clk_sys) disable iff (sys_rst) (|conv_valid) && (|ch_active) |-> ##[1:3] !data_ready_n;
    endproperty
    a_pulse: assert property (p_pulse) else $error("no ready pulse after capture");

    property p_sdo_stable;
        @(posedge clk_sys) disable iff (sys_rst) !cs_n && sck && $past(sck) |-> $stable({sdo, sdo_oe});
    endproperty
    a_sdo_stable: assert property (p_sdo_stable) else $error("sdo moved while sck high");

    property p_oe_idle;
        @(posedge clk_sys) disable iff (sys_rst) cs_n && $past(cs_n) |-> !sdo_oe;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("sdo driven outside a frame");

    property p_oe_ctrl;
        @(posedge sck) disable iff (sys_rst) edge_cnt_ff != 4'h8 |-> !sdo_oe;
    endproperty
    a_oe_ctrl: assert property (p_oe_ctrl) else $error("sdo driven during control byte");

    property p_rd_drive;
        @(posedge sck) disable iff (sys_rst) edge_cnt_ff == 4'h8 && ctrl_ff[0] |-> sdo_oe;
    endproperty
    a_rd_drive: assert property (p_rd_drive) else $error("read frame not driven");

    property p_wr_quiet;
        @(posedge sck) disable iff (sys_rst) edge_cnt_ff == 4'h8 && !ctrl_ff[0] |-> !sdo_oe;
    endproperty
    a_wr_quiet: assert property (p_wr_quiet) else $error("write frame drives sdo");
endmodule
`default_nettype wire

// [test/aolcl_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module aolcl_host_model (
    // clock, select and data toward the device
    output logic sck,
    output logic cs_n,
    output logic sdi,
    // device output and its enable
    input wire logic sdo,
    input wire logic sdo_oe
);
    logic [23:0] wq[$];
    logic rx[$];
    event done_ev;

    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end

    // sck only runs inside a frame; an undriven sdo reads inverted so a missing drive shows
    task automatic xfer(input logic [7:0] ctrl, input int n);
        rx.delete();
        #7;
        cs_n = 1'b0;
        for (int i = 0; i < n + 8; i++) begin
            if (i < 8) sdi = ctrl[7 - i];
            else if (ctrl[0]) sdi = ~sdi;
            else sdi = wq[(i - 8) / 24][23 - (i - 8) % 24];
            #80;
            sck = 1'b1;
            if (i >= 8) rx.push_back(sdo_oe ? sdo : ~sdo);
            #80;
            sck = 1'b0;
        end
        // select held so a written word lands before the frame closes
        #640;
        cs_n = 1'b1;
        sdi = ~sdi;
        wq.delete();
        #160;
        if (ctrl[0]) ->done_ev;
        #1;
    endtask
endmodule
`default_nettype wire
